/* File: bench/rtc_clock_model.sv */
// Purpose: Time-of-day source and second tick seen by the trigger block.
// Assumes: Runs from reset; date is a fixed parameter.
// Notes: No minute rollover, so a run must stay under one minute.
`timescale 1ns/100ps

module rtc_clock_model #(
  parameter TICK = 40,
  parameter DATE = 32'h07e9_0612
) (
  input wire mclk,
  input wire reset,
  output reg [31:0] now_date,
  output reg [31:0] now_time,
  output reg sec_tick
);
  integer cnt_reg;

  // A short second keeps the run brief; tick and time advance together.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 0;
      now_date <= DATE;
      now_time <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (cnt_reg == TICK - 1);
      if (cnt_reg == TICK - 1) begin
        cnt_reg <= 0;
        now_time <= now_time + 32'h0000_0001;
      end else begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
endmodule // rtc_clock_model

/* File: bench/rtc_trigger_checker.sv */
// Purpose: Port-level checks of the recording trigger block.
// Assumes: Sees only the top ports; shadows the control word.
// Notes: Duration stops are excluded near a second tick.
`timescale 1ns/100ps
`include "rtc_map.vh"

module rtc_trigger_checker #(
  parameter VAL_W = 32
) (
  input wire mclk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [31:0] now_date,
  input wire [31:0] now_time,
  input wire sec_tick,
  input wire mem_key,
  input wire mem_full,
  input wire avg_valid,
  input wire signed [VAL_W-1:0] avg_value,
  input wire rec_active,
  input wire rec_start,
  input wire rec_stop
);
  reg [31:0] ctrl_reg;
  wire ctl_wr;

  default clocking dclk @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Shadow of the control word, so mode-dependent checks know the mode.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 32'h0000_0200;
    end else if (ctl_wr) begin
      ctrl_reg <= reg_wdata;
    end
  end
  assign ctl_wr = reg_wr && (reg_addr == `RTC_OFS_CTRL);

  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_start_edge: assert property (
    rec_start |-> rec_active && !$past(rec_active))
    else $error("start pulse without a new recording");
  a_stop_edge: assert property ($fell(rec_active) |-> rec_stop)
    else $error("recording ended without a stop pulse");
  a_stop_clean: assert property (rec_stop |-> !rec_active)
    else $error("stop pulse while still recording");
  a_full_stop: assert property (
    rec_active && mem_full |=> rec_stop && !rec_active)
    else $error("memory full did not stop recording");
  a_key_stop: assert property (
    rec_active && mem_key && ctrl_reg[9:8] == `RTC_STOP_MAN |=> rec_stop)
    else $error("key did not stop a manual-stop recording");
  a_imm_hold: assert property (
    rec_active && mem_key && ctrl_reg[9:8] == `RTC_STOP_IMM && !mem_full
    && !ctl_wr && !sec_tick && !$past(sec_tick) && !$past(sec_tick, 2)
    |=> rec_active)
    else $error("key stopped an immediate-stop recording");
  // The enable bit lands one edge after the write and the registered
  // outputs follow one edge later, so the stop shows two edges on.
  a_disable_stop: assert property (
    rec_active && ctl_wr && !reg_wdata[0] |-> ##2 rec_stop && !rec_active)
    else $error("disable did not stop recording at once");
  a_no_start_off: assert property (
    !ctrl_reg[0] && !$past(ctrl_reg[0]) |-> !rec_start)
    else $error("recording started while disabled");
endmodule // rtc_trigger_checker

bind rtc_trigger rtc_trigger_checker #(.VAL_W(VAL_W)) chk_u (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .now_date(now_date), .now_time(now_time), .sec_tick(sec_tick),
  .mem_key(mem_key), .mem_full(mem_full), .avg_valid(avg_valid),
  .avg_value(avg_value), .rec_active(rec_active), .rec_start(rec_start),
  .rec_stop(rec_stop));

/* File: bench/rtc_trigger_tb.sv */
// Purpose: Self-checking bench for the recording trigger block.
// Assumes: Clock model supplies time of day; bench drives the rest.
// Notes: Status expectations are {cause, state} with state 3 as done.
`timescale 1ns/100ps
`include "rtc_map.vh"

module rtc_trigger_tb;
  reg mclk, reset, reg_wr, reg_rd, mem_key, mem_full, avg_valid;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, t0;
  reg signed [31:0] avg_value;
  wire [31:0] reg_rdata, now_date, now_time;
  wire sec_tick, rec_active, rec_start, rec_stop;
  integer mismatches, n_tests;

  rtc_clock_model clk_u (.mclk(mclk), .reset(reset), .now_date(now_date),
    .now_time(now_time), .sec_tick(sec_tick));
  rtc_trigger #(.VAL_W(32)) dut_u (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .now_date(now_date),
    .now_time(now_time), .sec_tick(sec_tick), .mem_key(mem_key),
    .mem_full(mem_full), .avg_valid(avg_valid), .avg_value(avg_value),
    .rec_active(rec_active), .rec_start(rec_start), .rec_stop(rec_stop));

  // 40 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ------
  // Access tasks
  // ------
  task conclude;
    begin
      $display("mismatches %0d of %0d checks", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
    end
  endtask
  task key;
    begin
      @(posedge mclk);
      mem_key <= 1'b1;
      @(posedge mclk);
      mem_key <= 1'b0;
    end
  endtask
  task samp(input [31:0] v);
    begin
      @(posedge mclk);
      avg_valid <= 1'b1;
      avg_value <= v;
      @(posedge mclk);
      avg_valid <= 1'b0;
    end
  endtask
  task act(input v);
    begin
      repeat (4) @(posedge mclk);
      #1;
      chk({31'h0, rec_active}, {31'h0, v});
    end
  endtask
  // Bounded wait; running out ends the run as a failure.
  task wact(input v);
    integer i;
    begin
      i = 0;
      while (rec_active !== v && i < 600) begin
        @(posedge mclk);
        #1;
        i = i + 1;
      end
      if (rec_active !== v) begin
        mismatches = mismatches + 1;
        $display("BAD %0t: recording wait ran out", $time);
        conclude;
      end
    end
  endtask

  // ------
  // Scenarios
  // ------
  initial begin
    mismatches = 0;
    n_tests = 0;
    reset = 1'b1;
    {reg_wr, reg_rd, mem_key, mem_full, avg_valid} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    avg_value = 32'sh0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rchk(`RTC_OFS_CTRL, 32'h0000_0200);
    rchk(`RTC_OFS_START_DATE, 32'h07b2_0101);
    rchk(`RTC_OFS_START_TIME, 32'h0);
    rchk(`RTC_OFS_STOP_DATE, 32'h07b2_0101);
    rchk(`RTC_OFS_STOP_TIME, 32'h0);
    rchk(`RTC_OFS_START_LEVEL, 32'h0);
    rchk(`RTC_OFS_STOP_LEVEL, 32'h0);
    rchk(8'h3c, 32'h0);
    // Time start and time stop, a few seconds ahead.
    t0 = now_time;
    wr(`RTC_OFS_START_DATE, now_date);
    wr(`RTC_OFS_START_TIME, t0 + 32'h3);
    wr(`RTC_OFS_STOP_DATE, now_date);
    wr(`RTC_OFS_STOP_TIME, t0 + 32'h5);
    wr(`RTC_OFS_CTRL, 32'h0000_0121);
    act(1'b0);
    wact(1'b1);
    chk(now_time, t0 + 32'h3);
    wact(1'b0);
    chk(now_time, t0 + 32'h5);
    rchk(`RTC_OFS_STATUS, 32'h0000_0033);
    // Rising start at 100, falling stop at 50.
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_START_LEVEL, 32'd100);
    wr(`RTC_OFS_STOP_LEVEL, 32'd50);
    wr(`RTC_OFS_CTRL, 32'h0000_2341);
    samp(32'd120);
    samp(32'd100);
    act(1'b0);
    samp(32'd90);
    samp(32'd100);
    act(1'b1);
    samp(32'd40);
    samp(32'd70);
    act(1'b1);
    samp(32'd50);
    wact(1'b0);
    rchk(`RTC_OFS_STATUS, 32'h0000_0053);
    // Immediate start, default key stop.
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_CTRL, 32'h0000_0201);
    wact(1'b1);
    key;
    act(1'b0);
    rchk(`RTC_OFS_STATUS, 32'h0000_0043);
    // Immediate stop ignores the key; disable stops at once.
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wact(1'b1);
    key;
    act(1'b1);
    wr(`RTC_OFS_CTRL, 32'h0);
    // The enable lands at the write edge; the output drops one edge later.
    @(posedge mclk);
    #1;
    chk({31'h0, rec_active}, 32'h0);
    // Memory full, then duration limit.
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wact(1'b1);
    @(posedge mclk);
    mem_full <= 1'b1;
    wact(1'b0);
    @(posedge mclk);
    mem_full <= 1'b0;
    rchk(`RTC_OFS_STATUS, 32'h0000_0013);
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_DURATION, 32'h2);
    wr(`RTC_OFS_CTRL, 32'h0000_0001);
    wact(1'b1);
    wact(1'b0);
    rchk(`RTC_OFS_STATUS, 32'h0000_0023);
    rchk(`RTC_OFS_ELAPSED, 32'h2);
    wr(`RTC_OFS_DURATION, 32'h0);
    // Bus trigger is ignored while disabled, then starts.
    wr(`RTC_OFS_CTRL, 32'h0000_0210);
    wr(`RTC_OFS_CMD, 32'h1);
    act(1'b0);
    wr(`RTC_OFS_CTRL, 32'h0000_0211);
    act(1'b0);
    wr(`RTC_OFS_CMD, 32'h1);
    wact(1'b1);
    // Manual start by the key.
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_CTRL, 32'h0000_0231);
    act(1'b0);
    key;
    wact(1'b1);
    key;
    wact(1'b0);
    conclude;
  end
endmodule // rtc_trigger_tb

/* File: src/rtc_cross_detect.v */
// Purpose: Detects a crossing of a level by successive averaged values.
// Assumes: Values are signed two's complement, one per sample strobe.
// Notes: Clear forgets the last sample so that stale data cannot fire.
`timescale 1ns/100ps

module rtc_cross_detect #(
  parameter WIDTH = 32
) (
  input wire mclk,
  input wire reset,
  input wire clear,
  input wire sample_valid,
  input wire signed [WIDTH-1:0] sample,
  input wire signed [WIDTH-1:0] level,
  input wire falling,
  output reg hit_reg
);

  reg signed [WIDTH-1:0] prev_reg;
  reg prev_valid_reg;
  wire rise_hit;
  wire fall_hit;

  // ----------------------------------------------------------------------
  // Crossing tests
  // ----------------------------------------------------------------------
  // From below to at-or-above, or from above to at-or-below the level.
  assign rise_hit = prev_valid_reg && (prev_reg < level) && (sample >= level);
  assign fall_hit = prev_valid_reg && (prev_reg > level) && (sample <= level);

  // Keep the previous value and raise a one-cycle hit on a crossing.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev_reg <= {WIDTH{1'b0}};
      prev_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else if (clear) begin
      prev_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= 1'b0;
      if (sample_valid) begin
        prev_reg <= sample;
        prev_valid_reg <= 1'b1;
        hit_reg <= falling ? fall_hit : rise_hit;
      end
    end
  end

endmodule // rtc_cross_detect

/* File: src/rtc_datetime_match.v */
// Purpose: Flags each cycle in which the time of day equals a set moment.
// Assumes: Date and time words use the same packing on both sides.
// Notes: The flag is registered, so it trails the clock value by one cycle.
`timescale 1ns/100ps

module rtc_datetime_match (
  input wire mclk,
  input wire reset,
  input wire [31:0] now_date,
  input wire [31:0] now_time,
  input wire [31:0] set_date,
  input wire [31:0] set_time,
  output reg match_reg
);

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // Every field is compared, so a new year with the same clock reading
  // never fires by mistake.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= (now_date == set_date) && (now_time == set_time);
    end
  end

endmodule // rtc_datetime_match

/* File: src/rtc_map.vh */
// Purpose: Offsets, field positions and reset values of the trigger block.
// Assumes: Included by the top trigger module and the bench; the detectors do not use it.
// Notes: Byte addresses on the plain register port, one 32-bit word each.
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTC_ADDR_W 8
`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_STATUS 8'h04
`define RTC_OFS_START_DATE 8'h08
`define RTC_OFS_START_TIME 8'h0c
`define RTC_OFS_STOP_DATE 8'h10
`define RTC_OFS_STOP_TIME 8'h14
`define RTC_OFS_START_LEVEL 8'h18
`define RTC_OFS_STOP_LEVEL 8'h1c
`define RTC_OFS_DURATION 8'h20
`define RTC_OFS_ELAPSED 8'h24
`define RTC_OFS_CMD 8'h28

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define RTC_CTRL_EN 0
`define RTC_CTRL_START_SRC_LO 4
`define RTC_CTRL_START_SRC_HI 6
`define RTC_CTRL_STOP_SRC_LO 8
`define RTC_CTRL_STOP_SRC_HI 9
`define RTC_CTRL_START_SLOPE 12
`define RTC_CTRL_STOP_SLOPE 13
`define RTC_CMD_BUS_TRIG 0

// Start sources.
`define RTC_START_IMM 3'h0
`define RTC_START_BUS 3'h1
`define RTC_START_TIME 3'h2
`define RTC_START_MAN 3'h3
`define RTC_START_FUNC 3'h4
// Stop sources.
`define RTC_STOP_IMM 2'h0
`define RTC_STOP_TIME 2'h1
`define RTC_STOP_MAN 2'h2
`define RTC_STOP_FUNC 2'h3
// Slope codes.
`define RTC_SLOPE_POS 1'b0
`define RTC_SLOPE_NEG 1'b1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
// Date word is {year[15:0], month[7:0], day[7:0]}.
`define RTC_RST_DATE 32'h07b2_0101
// Time word is {8'h00, hour[7:0], minute[7:0], second[7:0]}.
`define RTC_RST_TIME 32'h0000_0000
`define RTC_RST_LEVEL 32'h0000_0000
`define RTC_RST_DURATION 32'h0000_0000

// Stop causes shown in the status word.
`define RTC_CAUSE_NONE 3'h0
`define RTC_CAUSE_FULL 3'h1
`define RTC_CAUSE_DUR 3'h2
`define RTC_CAUSE_TIME 3'h3
`define RTC_CAUSE_MAN 3'h4
`define RTC_CAUSE_FUNC 3'h5

`endif

/* File: src/rtc_trigger.v */
// Purpose: Start and stop trigger control for memory recording.
// Assumes: Time of day, second tick and averaged values come from outside.
// Notes: Registers sit on a plain port; read data appear one cycle later.
//
// Operation
// - Time start fires when clock equals start moment.
// - Date and time held as separate fields.
// - Function start fires at start level.
// - Start slope picks rising or falling crossing.
// - Reset start source is immediate start.
// - Acquisition ends on first of all stop events.
// - Time stop adds the stop moment.
// - Immediate stop adds no extra condition.
// - Manual stop, the default, uses the key.
// - Disabling recording stops it at once.
// - Function stop ends on function condition.
// - Time stop fires when clock equals stop moment.
// - Function stop fires at stop level.
// - Stop slope picks rising or falling crossing.
// - Triggers act only while recording is enabled.
// - Bus start fires on host trigger command.
// - Manual start fires on the record key.
`timescale 1ns/100ps
`include "rtc_map.vh"

module rtc_trigger #(
  parameter VAL_W = 32
) (
  input wire mclk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [31:0] now_date,
  input wire [31:0] now_time,
  input wire sec_tick,
  input wire mem_key,
  input wire mem_full,
  input wire avg_valid,
  input wire signed [VAL_W-1:0] avg_value,
  output reg rec_active,
  output reg rec_start,
  output reg rec_stop
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_REC = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg en_reg;
  reg [2:0] start_src_reg;
  reg [1:0] stop_src_reg;
  reg start_slope_reg;
  reg stop_slope_reg;
  reg [31:0] start_date_reg;
  reg [31:0] start_time_reg;
  reg [31:0] stop_date_reg;
  reg [31:0] stop_time_reg;
  reg signed [VAL_W-1:0] start_level_reg;
  reg signed [VAL_W-1:0] stop_level_reg;
  reg [31:0] duration_reg;
  reg [31:0] elapsed_reg;
  reg bus_trig_reg;
  reg [2:0] cause_reg;
  reg [2:0] cause_next;
  reg start_ev;
  wire start_time_hit;
  wire stop_time_hit;
  wire start_func_hit;
  wire stop_func_hit;
  wire dur_hit;
  wire [31:0] ctrl_word;
  wire [31:0] status_word;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Software owns every setting; the bus trigger is a one-cycle command
  // bit that never reads back.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      en_reg <= 1'b0;
      start_src_reg <= `RTC_START_IMM;
      stop_src_reg <= `RTC_STOP_MAN;
      start_slope_reg <= `RTC_SLOPE_POS;
      stop_slope_reg <= `RTC_SLOPE_POS;
      start_date_reg <= `RTC_RST_DATE;
      start_time_reg <= `RTC_RST_TIME;
      stop_date_reg <= `RTC_RST_DATE;
      stop_time_reg <= `RTC_RST_TIME;
      start_level_reg <= `RTC_RST_LEVEL;
      stop_level_reg <= `RTC_RST_LEVEL;
      duration_reg <= `RTC_RST_DURATION;
      bus_trig_reg <= 1'b0;
    end else begin
      bus_trig_reg <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `RTC_OFS_CTRL: begin
            en_reg <= reg_wdata[`RTC_CTRL_EN];
            start_src_reg <=
              reg_wdata[`RTC_CTRL_START_SRC_HI:`RTC_CTRL_START_SRC_LO];
            stop_src_reg <=
              reg_wdata[`RTC_CTRL_STOP_SRC_HI:`RTC_CTRL_STOP_SRC_LO];
            start_slope_reg <= reg_wdata[`RTC_CTRL_START_SLOPE];
            stop_slope_reg <= reg_wdata[`RTC_CTRL_STOP_SLOPE];
          end
          // Date and time words keep each field in its own byte lanes.
          `RTC_OFS_START_DATE: start_date_reg <= reg_wdata;
          `RTC_OFS_START_TIME: start_time_reg <= reg_wdata;
          `RTC_OFS_STOP_DATE: stop_date_reg <= reg_wdata;
          `RTC_OFS_STOP_TIME: stop_time_reg <= reg_wdata;
          `RTC_OFS_START_LEVEL: start_level_reg <= reg_wdata[VAL_W-1:0];
          `RTC_OFS_STOP_LEVEL: stop_level_reg <= reg_wdata[VAL_W-1:0];
          `RTC_OFS_DURATION: duration_reg <= reg_wdata;
          `RTC_OFS_CMD: bus_trig_reg <= reg_wdata[`RTC_CMD_BUS_TRIG];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  assign ctrl_word = {18'h00000, stop_slope_reg, start_slope_reg,
                      2'h0, stop_src_reg, 1'b0, start_src_reg, 3'h0, en_reg};
  assign status_word = {24'h000000, 1'b0, cause_reg, 2'h0, state_reg};

  // Read data stand only in the cycle after the strobe, zero otherwise,
  // and unmapped or write-only offsets read as zero.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RTC_OFS_CTRL: reg_rdata <= ctrl_word;
        `RTC_OFS_STATUS: reg_rdata <= status_word;
        `RTC_OFS_START_DATE: reg_rdata <= start_date_reg;
        `RTC_OFS_START_TIME: reg_rdata <= start_time_reg;
        `RTC_OFS_STOP_DATE: reg_rdata <= stop_date_reg;
        `RTC_OFS_STOP_TIME: reg_rdata <= stop_time_reg;
        `RTC_OFS_START_LEVEL: reg_rdata <= start_level_reg;
        `RTC_OFS_STOP_LEVEL: reg_rdata <= stop_level_reg;
        `RTC_OFS_DURATION: reg_rdata <= duration_reg;
        `RTC_OFS_ELAPSED: reg_rdata <= elapsed_reg;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Event detectors
  // ----------------------------------------------------------------------
  rtc_datetime_match u_start_time (
    .mclk(mclk),
    .reset(reset),
    .now_date(now_date),
    .now_time(now_time),
    .set_date(start_date_reg),
    .set_time(start_time_reg),
    .match_reg(start_time_hit)
  );

  rtc_datetime_match u_stop_time (
    .mclk(mclk),
    .reset(reset),
    .now_date(now_date),
    .now_time(now_time),
    .set_date(stop_date_reg),
    .set_time(stop_time_reg),
    .match_reg(stop_time_hit)
  );

  // Each detector is cleared outside its own phase, so a crossing is only
  // judged between two samples taken while that trigger is waiting.
  rtc_cross_detect #(
    .WIDTH(VAL_W)
  ) u_start_cross (
    .mclk(mclk),
    .reset(reset),
    .clear(state_reg != ST_ARMED),
    .sample_valid(avg_valid),
    .sample(avg_value),
    .level(start_level_reg),
    .falling(start_slope_reg),
    .hit_reg(start_func_hit)
  );

  rtc_cross_detect #(
    .WIDTH(VAL_W)
  ) u_stop_cross (
    .mclk(mclk),
    .reset(reset),
    .clear(state_reg != ST_REC),
    .sample_valid(avg_valid),
    .sample(avg_value),
    .level(stop_level_reg),
    .falling(stop_slope_reg),
    .hit_reg(stop_func_hit)
  );

  // ----------------------------------------------------------------------
  // Recording time
  // ----------------------------------------------------------------------
  // A duration of zero means no time limit, so a fresh reset never ends
  // a recording on its own.
  assign dur_hit = (duration_reg != 32'h0000_0000) &&
                   (elapsed_reg >= duration_reg);

  // Seconds are counted only while recording and restart at each start.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      elapsed_reg <= 32'h0000_0000;
    end else if (state_reg == ST_ARMED) begin
      elapsed_reg <= 32'h0000_0000;
    end else if (state_reg == ST_REC && sec_tick) begin
      elapsed_reg <= elapsed_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Start selection
  // ----------------------------------------------------------------------
  always @* begin
    case (start_src_reg)
      `RTC_START_IMM: start_ev = 1'b1;
      `RTC_START_BUS: start_ev = bus_trig_reg;
      `RTC_START_TIME: start_ev = start_time_hit;
      `RTC_START_MAN: start_ev = mem_key;
      `RTC_START_FUNC: start_ev = start_func_hit;
      default: start_ev = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Stop selection
  // ----------------------------------------------------------------------
  // Memory full outranks the time limit, which outranks the chosen
  // source, so the reported cause is stable when events coincide.
  always @* begin
    cause_next = `RTC_CAUSE_NONE;
    if (mem_full) begin
      cause_next = `RTC_CAUSE_FULL;
    end else if (dur_hit) begin
      cause_next = `RTC_CAUSE_DUR;
    end else begin
      case (stop_src_reg)
        `RTC_STOP_TIME: begin
          if (stop_time_hit) begin
            cause_next = `RTC_CAUSE_TIME;
          end
        end
        `RTC_STOP_MAN: begin
          if (mem_key) begin
            cause_next = `RTC_CAUSE_MAN;
          end
        end
        `RTC_STOP_FUNC: begin
          if (stop_func_hit) begin
            cause_next = `RTC_CAUSE_FUNC;
          end
        end
        default: cause_next = `RTC_CAUSE_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Clearing the enable wins over every state; a finished recording waits
  // in DONE until software disables and enables again.
  always @* begin
    state_next = state_reg;
    if (!en_reg) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_next = ST_ARMED;
        ST_ARMED: begin
          if (start_ev) begin
            state_next = ST_REC;
          end
        end
        ST_REC: begin
          if (cause_next != `RTC_CAUSE_NONE) begin
            state_next = ST_DONE;
          end
        end
        ST_DONE: state_next = ST_DONE;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // State, cause and the registered recording outputs.
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cause_reg <= `RTC_CAUSE_NONE;
      rec_active <= 1'b0;
      rec_start <= 1'b0;
      rec_stop <= 1'b0;
    end else begin
      state_reg <= state_next;
      rec_active <= (state_next == ST_REC);
      rec_start <= (state_reg != ST_REC) && (state_next == ST_REC);
      rec_stop <= (state_reg == ST_REC) && (state_next != ST_REC);
      if (state_reg == ST_ARMED && state_next == ST_REC) begin
        cause_reg <= `RTC_CAUSE_NONE;
      end else if (state_reg == ST_REC && state_next == ST_DONE) begin
        cause_reg <= cause_next;
      end
    end
  end

endmodule // rtc_trigger
